// ---- pkg/rscl_pkg.sv ----
// constants shared by the strap and serial-rom configuration loader
package rscl_pkg;
   // clock and serial clock timing
   localparam int CLK_PERIOD_NS = 40;
   localparam int SK_HALF_NS = 1000; // least half period of the serial clock
   localparam int SK_HALF_CYC = (SK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int DIV_W = $clog2(SK_HALF_CYC + 1);
   // serial read command framing
   localparam int ROM_ADDR_W = 6;
   localparam int CMD_BITS = 3 + ROM_ADDR_W;
   localparam logic [2:0] READ_CMD = 3'h6; // start bit then read opcode
   localparam int FIRST_SAMPLE = CMD_BITS + 1; // dummy zero precedes data
   localparam int LAST_RISE = FIRST_SAMPLE + 15;
   localparam int BIT_CNT_W = 5;
   // id-prom image
   localparam int PROM_WORDS = 16;
   localparam int PROM_IDX_W = $clog2(PROM_WORDS);
   // pin usage
   localparam int THIN_BIT = 7; // bit of configuration register a
   localparam logic [7:0] EE_LOW_OE = 8'h06; // serial in and serial clock driven
   localparam logic [7:0] ALL_OFF = 8'h00;
   localparam logic [7:0] ALL_ON = 8'hFF;
   localparam logic [7:0] CFG_CLEAR = 8'h00;
endpackage : rscl_pkg

// ---- pkg/rscl_ee_if.sv ----
// signals between the core and the serial rom reader
interface rscl_ee_if;
   logic start;
   logic busy;
   logic sk;
   logic si;
   logic so_in;
   logic cs;
   logic wr_en;
   logic [rscl_pkg::PROM_IDX_W-1:0] wr_idx;
   logic [15:0] wr_data;
   modport rdr (input start, input so_in, output busy, output sk, output si, output cs,
      output wr_en, output wr_idx, output wr_data);
   modport core (output start, output so_in, input busy, input sk, input si, input cs,
      input wr_en, input wr_idx, input wr_data);
endinterface : rscl_ee_if

// ---- rtl/rscl_ee_reader.sv ----
// serial rom reader: one read command per word, words written to the prom image
module rscl_ee_reader #(
   parameter int WORDS = rscl_pkg::PROM_WORDS
) (
   // clock and reset
   input wire logic mclk,
   input wire logic resetn,
   // core side
   rscl_ee_if.rdr ee
);
   typedef enum logic [2:0] {RSCL_IDLE, RSCL_SEL, RSCL_SHIFT, RSCL_DESEL} rscl_st_t;

   rscl_st_t st_r;
   logic [rscl_pkg::DIV_W-1:0] div_r;
   logic [rscl_pkg::BIT_CNT_W-1:0] bit_r;
   logic [rscl_pkg::PROM_IDX_W-1:0] idx_r;
   logic [15:0] shift_r;
   logic sk_r;
   logic si_r;
   logic cs_r;
   logic wr_r;
   logic tick;
   logic last_word;

   // command bit for a given rise count, msb first
   function automatic logic cmd_bit(input logic [rscl_pkg::PROM_IDX_W-1:0] idx,
      input logic [rscl_pkg::BIT_CNT_W-1:0] n);
      logic [rscl_pkg::CMD_BITS-1:0] cmd;
      cmd = {rscl_pkg::READ_CMD, rscl_pkg::ROM_ADDR_W'(idx)};
      cmd_bit = (n < rscl_pkg::BIT_CNT_W'(rscl_pkg::CMD_BITS)) ?
         cmd[rscl_pkg::CMD_BITS - 1 - int'(n)] : 1'b0;
   endfunction

   // half-period enable and decodes
   assign tick = (div_r == rscl_pkg::DIV_W'(rscl_pkg::SK_HALF_CYC - 1));
   assign last_word = (idx_r == rscl_pkg::PROM_IDX_W'(WORDS - 1));
   assign ee.busy = (st_r != RSCL_IDLE);
   assign ee.sk = sk_r;
   assign ee.si = si_r;
   assign ee.cs = cs_r;
   assign ee.wr_en = wr_r;
   assign ee.wr_idx = idx_r;
   assign ee.wr_data = shift_r;

   // serial clock divider, runs only while busy
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) div_r <= '0;
      else if (st_r == RSCL_IDLE || tick) div_r <= '0;
      else div_r <= div_r + 1'b1;
   end

   // read sequencer: data changes with clock low, sampled before each rise
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         st_r <= RSCL_IDLE;
         bit_r <= '0;
         idx_r <= '0;
         shift_r <= '0;
         sk_r <= 1'b0;
         si_r <= 1'b0;
         cs_r <= 1'b0;
         wr_r <= 1'b0;
      end else begin
         wr_r <= 1'b0;
         case (st_r)
            RSCL_IDLE: begin
               if (ee.start) begin
                  st_r <= RSCL_SEL;
                  idx_r <= '0;
               end
            end
            RSCL_SEL: begin
               // step to the next word once the previous one has been written
               if (wr_r) idx_r <= idx_r + 1'b1;
               if (tick) begin
                  cs_r <= 1'b1;
                  bit_r <= '0;
                  si_r <= cmd_bit(idx_r, '0);
                  st_r <= RSCL_SHIFT;
               end
            end
            RSCL_SHIFT: begin
               if (tick && !sk_r) begin
                  sk_r <= 1'b1;
                  if (bit_r >= rscl_pkg::BIT_CNT_W'(rscl_pkg::FIRST_SAMPLE))
                     shift_r <= {shift_r[14:0], ee.so_in};
               end else if (tick) begin
                  sk_r <= 1'b0;
                  bit_r <= bit_r + 1'b1;
                  si_r <= cmd_bit(idx_r, bit_r + 1'b1);
                  if (bit_r == rscl_pkg::BIT_CNT_W'(rscl_pkg::LAST_RISE))
                     st_r <= RSCL_DESEL;
               end
            end
            RSCL_DESEL: begin
               if (tick) begin
                  cs_r <= 1'b0;
                  si_r <= 1'b0;
                  wr_r <= 1'b1;
                  st_r <= last_word ? RSCL_IDLE : RSCL_SEL;
               end
            end
            default: st_r <= RSCL_IDLE;
         endcase
      end
   end
endmodule // rscl_ee_reader

// ---- rtl/rscl_top.sv ----
// reset strap capture and serial rom configuration loader
module rscl_top #(
   parameter int WORDS = rscl_pkg::PROM_WORDS
) (
   // clock and reset
   input wire logic mclk,
   input wire logic resetn,
   // low memory data pins, also register a straps and serial rom pins
   input wire logic [7:0] mem_support_data_low_in,
   output logic [7:0] mem_support_data_low_out,
   output logic [7:0] mem_support_data_low_oe,
   // high memory data pins, also register b straps
   input wire logic [7:0] mem_support_data_high_in,
   output logic [7:0] mem_support_data_high_out,
   output logic [7:0] mem_support_data_high_oe,
   // memory address pins one to eight, also register c straps
   input wire logic [8:1] mem_support_addr_low_in,
   output logic [8:1] mem_support_addr_low_out,
   output logic [8:1] mem_support_addr_low_oe,
   // serial rom select and load strap
   output logic rom_select,
   input wire logic load_from_serial_rom_pin,
   // media indicator
   output logic thin_cable,
   // memory access from the controller core
   input wire logic mem_req,
   input wire logic mem_write,
   input wire logic [8:1] mem_addr,
   input wire logic [15:0] mem_wdata,
   output logic mem_ready,
   output logic [15:0] mem_rdata,
   // configuration and prom image read port
   output logic [7:0] cfg_a,
   output logic [7:0] cfg_b,
   output logic [7:0] cfg_c,
   output logic cfg_loading,
   input wire logic prom_rd_en,
   input wire logic [rscl_pkg::PROM_IDX_W-1:0] prom_rd_idx,
   output logic [15:0] prom_rd_data
);
   logic [7:0] cfg_a_r;
   logic [7:0] cfg_b_r;
   logic [7:0] cfg_c_r;
   logic released_r;
   logic drive_r;
   logic [15:0] wdata_r;
   logic [8:1] addr_r;
   logic [15:0] rdata_r;
   logic [15:0] prom_data_r;
   logic [15:0] prom_mem [WORDS];
   logic load_start;
   logic loading;
   logic user_ok;
   logic [7:0] low_oe_user;
   logic [7:0] low_out_ee;

   rscl_ee_if ee ();

   rscl_ee_reader #(
      .WORDS(WORDS)
   ) u_reader (
      .mclk(mclk),
      .resetn(resetn),
      .ee(ee.rdr)
   );

   // strap capture: no async reset so the flops can sample while reset is low
   always_ff @(posedge mclk) begin
      if (!resetn) begin
         cfg_a_r <= mem_support_data_low_in;
         cfg_b_r <= mem_support_data_high_in;
         cfg_c_r <= mem_support_addr_low_in;
      end
   end

   // marks the first edge after reset release
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) released_r <= 1'b0;
      else released_r <= 1'b1;
   end

   // load start and pin ownership decodes
   assign load_start = !released_r && load_from_serial_rom_pin;
   assign loading = ee.busy;
   assign user_ok = released_r && !loading;
   assign ee.start = load_start;
   assign ee.so_in = mem_support_data_low_in[0];
   assign low_out_ee = {5'h00, ee.sk, ee.si, 1'b0};
   assign low_oe_user = drive_r ? rscl_pkg::ALL_ON : rscl_pkg::ALL_OFF;

   // pin drivers: everything floats until release so straps are undisturbed
   assign mem_support_data_low_out = loading ? low_out_ee : wdata_r[7:0];
   assign mem_support_data_low_oe = !released_r ? rscl_pkg::ALL_OFF :
      (loading ? rscl_pkg::EE_LOW_OE : low_oe_user);
   assign mem_support_data_high_out = wdata_r[15:8];
   assign mem_support_data_high_oe = (released_r && !loading) ? low_oe_user :
      rscl_pkg::ALL_OFF;
   assign mem_support_addr_low_out = addr_r;
   assign mem_support_addr_low_oe = released_r ? rscl_pkg::ALL_ON : rscl_pkg::ALL_OFF;
   assign rom_select = ee.cs;

   // status and configuration outputs
   assign thin_cable = cfg_a_r[rscl_pkg::THIN_BIT];
   assign cfg_a = cfg_a_r;
   assign cfg_b = cfg_b_r;
   assign cfg_c = cfg_c_r;
   assign cfg_loading = loading;
   assign mem_ready = user_ok;
   assign mem_rdata = rdata_r;
   assign prom_rd_data = prom_data_r;

   // memory cycle registers: address, write data and drive direction
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         drive_r <= 1'b0;
         wdata_r <= '0;
         addr_r <= '0;
      end else begin
         drive_r <= user_ok && mem_req && mem_write;
         if (user_ok && mem_req) begin
            wdata_r <= mem_wdata;
            addr_r <= mem_addr;
         end
      end
   end

   // read data capture from both halves of the data bus
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) rdata_r <= '0;
      else if (user_ok && mem_req && !mem_write)
         rdata_r <= {mem_support_data_high_in, mem_support_data_low_in};
   end

   // prom image filled by the reader
   always_ff @(posedge mclk) begin
      if (ee.wr_en) prom_mem[ee.wr_idx] <= ee.wr_data;
   end

   // prom image read port
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) prom_data_r <= '0;
      else if (prom_rd_en) prom_data_r <= prom_mem[prom_rd_idx];
   end

   // checks
   thin_follow_a: assert property (@(posedge mclk) disable iff (!resetn)
      thin_cable == cfg_a[rscl_pkg::THIN_BIT])
      else $error("thin output differs from configuration");
   strap_a_cap_a: assert property (@(posedge mclk) disable iff (!resetn)
      !released_r |-> cfg_a == $past(mem_support_data_low_in))
      else $error("register a missed its straps");
   strap_b_cap_a: assert property (@(posedge mclk) disable iff (!resetn)
      !released_r |-> cfg_b == $past(mem_support_data_high_in))
      else $error("register b missed its straps");
   strap_c_cap_a: assert property (@(posedge mclk) disable iff (!resetn)
      !released_r |-> cfg_c == $past(mem_support_addr_low_in))
      else $error("register c missed its straps");
   strap_hold_a: assert property (@(posedge mclk) disable iff (!resetn)
      released_r |=> $stable(cfg_a) && $stable(cfg_b) && $stable(cfg_c))
      else $error("strap values changed after reset");
   float_reset_a: assert property (@(posedge mclk) disable iff (!resetn)
      !released_r |-> mem_support_data_low_oe == 8'h00 && mem_support_addr_low_oe == 8'h00)
      else $error("strap pins driven before release");
   load_go_a: assert property (@(posedge mclk) disable iff (!resetn)
      !released_r |=> cfg_loading == $past(load_from_serial_rom_pin))
      else $error("rom load start does not follow the strap");
   ee_pins_a: assert property (@(posedge mclk) disable iff (!resetn)
      cfg_loading |-> mem_support_data_low_oe == 8'h06 && !mem_ready)
      else $error("serial pins misassigned during load");
   prom_read_a: assert property (@(posedge mclk) disable iff (!resetn)
      prom_rd_en && !ee.wr_en |=> prom_rd_data == prom_mem[$past(prom_rd_idx)])
      else $error("prom image read wrong word");
   mem_write_a: assert property (@(posedge mclk) disable iff (!resetn)
      mem_ready && mem_req && mem_write |=> mem_support_data_high_oe == 8'hFF
         && mem_support_data_high_out == $past(mem_wdata[15:8]))
      else $error("high data lines not driven on write");
   addr_drive_a: assert property (@(posedge mclk) disable iff (!resetn)
      released_r |-> mem_support_addr_low_oe == 8'hFF)
      else $error("address lines undriven after release");

   load_seen_c: cover property (@(posedge mclk) disable iff (!resetn)
      $fell(cfg_loading));
   mem_write_c: cover property (@(posedge mclk) disable iff (!resetn)
      mem_ready && mem_req && mem_write);
   prom_read_c: cover property (@(posedge mclk) disable iff (!resetn)
      !cfg_loading && prom_rd_en);
endmodule // rscl_top

// ---- test/rscl_rom_model.sv ----
// serial configuration rom model answering read commands on four pins
module rscl_rom_model (
   // serial pins
   input wire logic cs,
   input wire logic sk,
   input wire logic si,
   output logic so
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [15:0] mem [64];
   logic [8:0] cmd;
   logic [15:0] word;
   int cnt;
   // released line shows the inverse of its last value
   initial so = 1'b0;
   always @(posedge cs) cnt = 0;
   always @(negedge cs) so = ~so;
   // command shifted in, dummy zero, then data msb first on each rising clock
   always @(posedge sk) begin
      if (cs) begin
         cnt = cnt + 1;
         if (cnt <= 9) cmd = {cmd[7:0], si};
         word = (cmd[8:6] == 3'h6) ? mem[cmd[5:0]] : ~mem[cmd[5:0]];
         so = (cnt == 9) ? 1'b0 : ((cnt > 9 && cnt < 26) ? word[25 - cnt] : ~so);
      end
   end
endmodule // rscl_rom_model

// ---- test/tb.sv ----
// self-checking bench for the strap and serial rom configuration loader
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic mclk, resetn, load_pin, mem_req, mem_write, prom_rd_en, was_wr;
   logic rom_select, thin_cable, mem_ready, cfg_loading, so;
   logic [7:0] lo_in, lo_out, lo_oe, hi_in, hi_out, hi_oe, cfg_a, cfg_b, cfg_c;
   logic [7:0] strap_a, strap_b, strap_c, ext_lo, ext_hi;
   logic [8:1] ad_in, ad_out, ad_oe, mem_addr, exp_ad;
   logic [15:0] mem_wdata, mem_rdata, prom_rd_data, exp_rd;
   logic [3:0] prom_rd_idx;
   int mismatches, n_checks;
   // pin levels: driver, straps in reset (pull-up 1, open 0), rom, external memory
   assign lo_in = (lo_oe & lo_out) | (~lo_oe & (!resetn ? strap_a :
      (rom_select ? {ext_lo[7:1], so} : ext_lo)));
   assign hi_in = (hi_oe & hi_out) | (~hi_oe & (resetn ? ext_hi : strap_b));
   assign ad_in = (ad_oe & ad_out) | (~ad_oe & (resetn ? ~strap_c : strap_c));
   rscl_top rscl_top_i (.mclk(mclk), .resetn(resetn),
      .mem_support_data_low_in(lo_in), .mem_support_data_low_out(lo_out),
      .mem_support_data_low_oe(lo_oe), .mem_support_data_high_in(hi_in),
      .mem_support_data_high_out(hi_out), .mem_support_data_high_oe(hi_oe),
      .mem_support_addr_low_in(ad_in), .mem_support_addr_low_out(ad_out),
      .mem_support_addr_low_oe(ad_oe), .rom_select(rom_select),
      .load_from_serial_rom_pin(load_pin), .thin_cable(thin_cable), .mem_req(mem_req),
      .mem_write(mem_write), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
      .mem_ready(mem_ready), .mem_rdata(mem_rdata), .cfg_a(cfg_a), .cfg_b(cfg_b),
      .cfg_c(cfg_c), .cfg_loading(cfg_loading), .prom_rd_en(prom_rd_en),
      .prom_rd_idx(prom_rd_idx), .prom_rd_data(prom_rd_data));
   rscl_rom_model rscl_rom_model_i (.cs(rom_select), .sk(lo_out[2]), .si(lo_out[1]), .so(so));
   // clock
   initial begin
      mclk = 1'b0;
      forever #20 mclk = ~mclk;
   end
   // compare and count
   task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
      n_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
      end
   endtask
   // verdict and end of run
   task automatic close_out();
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   // reset with random straps, release and follow the optional rom load
   task automatic reset_run(input logic ld);
      @(posedge mclk);
      resetn <= 1'b0;
      load_pin <= ld;
      strap_a <= 8'($urandom);
      strap_b <= 8'($urandom);
      strap_c <= 8'($urandom);
      repeat (20) @(posedge mclk);
      @(negedge mclk);
      chk("oe in reset", {lo_oe, hi_oe}, 16'h0000);
      chk("addr oe in reset", ad_oe, 8'h00);
      chk("cfg a", cfg_a, strap_a);
      chk("cfg b", cfg_b, strap_b);
      chk("cfg c", cfg_c, strap_c);
      chk("thin", thin_cable, strap_a[rscl_pkg::THIN_BIT]);
      @(posedge mclk);
      resetn <= 1'b1;
      repeat (3) @(posedge mclk);
      @(negedge mclk);
      chk("loading", cfg_loading, ld);
      chk("ready", mem_ready, !ld);
      chk("addr oe", ad_oe, 8'hFF);
      if (ld) chk("low oe in load", lo_oe, rscl_pkg::EE_LOW_OE);
      else chk("select", rom_select, 1'b0);
      for (int k = 0; k < 30000 && cfg_loading; k++) @(negedge mclk);
      chk("load end", {cfg_loading, mem_ready}, 2'h1);
   endtask
   // back-to-back random reads and writes, checked one cycle after each is taken
   task automatic mem_run(input int n);
      @(posedge mclk);
      for (int k = 0; k <= n; k++) begin
         mem_req <= (k < n);
         mem_write <= 1'($urandom);
         mem_addr <= 8'($urandom);
         mem_wdata <= 16'($urandom);
         ext_lo <= 8'($urandom);
         ext_hi <= 8'($urandom);
         @(negedge mclk);
         if (k > 0) begin
            chk("data oe", {hi_oe, lo_oe}, was_wr ? 16'hFFFF : 16'h0000);
            if (was_wr) chk("wdata", {hi_out, lo_out}, exp_rd);
            else chk("rdata", mem_rdata, exp_rd);
            chk("addr out", ad_out, exp_ad);
         end
         // a read right after a write still sees the bus driven with the written word
         exp_rd = mem_write ? mem_wdata : ((k > 0 && was_wr) ? exp_rd : {ext_hi, ext_lo});
         was_wr = mem_write;
         exp_ad = mem_addr;
         @(posedge mclk);
      end
   endtask
   // main sequence
   initial begin
      void'($urandom(65388));
      resetn = 1'b0;
      load_pin = 1'b0;
      {mem_req, mem_write, prom_rd_en, mem_addr, mem_wdata, prom_rd_idx} = '0;
      {strap_a, strap_b, strap_c, ext_lo, ext_hi} = '0;
      for (int k = 0; k < 64; k++) rscl_rom_model_i.mem[k] = 16'($urandom);
      reset_run(1'b1);
      for (int k = 0; k <= 16; k++) begin
         @(posedge mclk);
         prom_rd_en <= (k < 16);
         prom_rd_idx <= 4'(k);
         @(negedge mclk);
         if (k > 0) chk("prom word", prom_rd_data, rscl_rom_model_i.mem[k - 1]);
      end
      mem_run(40);
      chk("cfg kept", {cfg_a, cfg_b}, {strap_a, strap_b});
      chk("cfg c kept", cfg_c, strap_c);
      reset_run(1'b0);
      mem_run(20);
      close_out();
   end
   // hang guard
   initial begin
      repeat (80000) @(posedge mclk);
      mismatches++;
      close_out();
   end
endmodule // tb
